// ===== rtl/hcp_control_port.sv
// Two-wire bus slave control port with word buffers and flow control
// Function
// - Moves 8-bit units as a slave only; never clocks or starts transfers.
// - Pull data-ready request low while a message waits; release once read.
// - Pull busy low while the four-byte receive buffer is full.
// - Busy going low tells the host to stop sending bytes.
// - In native flow mode also hold the bus clock low to delay transfers.
// - Stretch the clock while not ready; release when a byte can move.
// - Capture the five boot-select pins as reset falls.
// - Answer address byte 0x80 for writes and 0x81 for reads.
// - Slave format selected at reset enables the port as a slave.
// - Start is data falling while clock high; only the master starts.
// - Stop is data rising while clock high; only the master stops.
// - Driven data stays unchanged while clock is high.
// - Bus busy from start until stop; repeated start acts as start.
// - Any byte count per transfer; bytes shift most-significant bit first.
// - First byte after start is 7-bit address plus direction bit.
// - Acknowledge a matching address on the ninth clock; else leave high.
// - Acknowledge each written byte; leave high for a byte that finds the buffer full.
// - Release data line after every acknowledge or not-acknowledge bit.
`timescale 1ns/1ps
`default_nettype none

module hcp_control_port #(
    parameter int          WORD_BYTES    = 4,
    parameter logic [4:0]  BOOT_I2C_SLAVE = 5'h01
) (
    input  wire logic                    clock,
    input  wire logic                    reset,
    input  wire logic                    link_clock,
    input  wire logic [4:0]              boot_select_pins,
    input  wire logic                    native_flow_enable,
    input  wire logic                    port_bit_clock_in,
    output var  logic                    port_bit_clock_out,
    output var  logic                    port_bit_clock_oe,
    input  wire logic                    port_serial_data_in,
    output var  logic                    port_serial_data_out,
    output var  logic                    port_serial_data_oe,
    output var  logic                    data_ready_request_n,
    output var  logic                    input_full_n,
    output var  logic [4:0]              boot_mode,
    output var  logic [8*WORD_BYTES-1:0] rx_word,
    output var  logic                    rx_valid,
    input  wire logic [8*WORD_BYTES-1:0] tx_word,
    input  wire logic                    tx_valid,
    output var  logic                    tx_ready
);
    localparam int WW = 8 * WORD_BYTES;
    localparam int IW = (WORD_BYTES > 1) ? $clog2(WORD_BYTES) : 1;
    localparam logic [IW-1:0] LAST_IDX = IW'(WORD_BYTES - 1);

    // Index arithmetic and the host word protocol assume this range
    if (WORD_BYTES < 1 || WORD_BYTES > 8)
    begin : g_bad_width
        $error("WORD_BYTES must lie between 1 and 8");
    end

    // Core domain state
    logic          reset_d1_q;
    logic [4:0]    bsel_s1_q, bsel_s2_q;
    logic          slave_mode_q;
    logic [WW-1:0] tx_hold_q;
    logic          tx_busy_q, tx_busy_d, tx_req_tgl_q;
    logic          txack_s1_q, txack_s2_q, txack_s3_q;
    logic          rxreq_s1_q, rxreq_s2_q, rxreq_s3_q;
    logic          rx_ack_tgl_q;

    // Link domain state
    logic                 lrst_s1_q, lrst;
    logic                 en_s1_q, en_s2_q;
    logic                 nat_s1_q, nat_s2_q;
    hcp_pkg::hcp_lines_t  lines_s1_q, lines_s2_q, lines_p_q;
    logic                 txreq_s1_q, txreq_s2_q, txreq_s3_q;
    logic                 rxack_s1_q, rxack_s2_q, rxack_s3_q;
    hcp_pkg::hcp_state_t  state_q;
    logic [3:0]           cnt_q;
    logic [7:0]           sh_q, tx_sh_q, tx_byte;
    logic                 rw_q, mack_q, bus_busy_q, full_q;
    logic                 tx_have_q, loaded_q;
    logic [IW-1:0]        wr_idx_q, rd_idx_q;
    logic [WW-1:0]        rx_word_l_q, tx_word_l_q;
    logic                 rx_req_tgl_q, tx_ack_tgl_q;
    logic                 scl_rise, scl_fall, start_w, stop_w;
    logic                 tx_new, rx_ack_seen, addr_hit;

    // Boot strap capture at reset release, pins synchronised first
    always_ff @(posedge clock)
    begin
        bsel_s1_q  <= boot_select_pins;
        bsel_s2_q  <= bsel_s1_q;
        reset_d1_q <= reset;
        if (reset)
        begin
            boot_mode    <= hcp_pkg::BOOT_SEL_RESET;
            slave_mode_q <= 1'b0;
        end
        else if (reset_d1_q)
        begin
            boot_mode    <= bsel_s2_q;
            slave_mode_q <= (bsel_s2_q == BOOT_I2C_SLAVE);
        end
    end

    // Outgoing word: held stable until the link returns its toggle
    always_comb
    begin
        tx_busy_d = tx_busy_q;
        if (tx_valid && tx_ready)
            tx_busy_d = 1'b1;
        else if (txack_s2_q != txack_s3_q)
            tx_busy_d = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        txack_s1_q <= tx_ack_tgl_q;
        txack_s2_q <= txack_s1_q;
        txack_s3_q <= txack_s2_q;
        if (reset)
        begin
            tx_busy_q            <= 1'b0;
            tx_req_tgl_q         <= 1'b0;
            tx_hold_q            <= '0;
            tx_ready             <= 1'b0;
            data_ready_request_n <= 1'b1;
        end
        else
        begin
            tx_busy_q <= tx_busy_d;
            tx_ready  <= ~tx_busy_d;
            // Low for as long as any word is waiting for the host
            data_ready_request_n <= ~tx_busy_q;
            if (tx_valid && tx_ready)
            begin
                tx_hold_q    <= tx_word;
                tx_req_tgl_q <= ~tx_req_tgl_q;
            end
        end
    end

    // Incoming word: link data is stable while its toggle is unanswered
    always_ff @(posedge clock)
    begin
        rxreq_s1_q <= rx_req_tgl_q;
        rxreq_s2_q <= rxreq_s1_q;
        rxreq_s3_q <= rxreq_s2_q;
        if (reset)
        begin
            rx_word      <= '0;
            rx_valid     <= 1'b0;
            rx_ack_tgl_q <= 1'b0;
        end
        else
        begin
            rx_valid <= (rxreq_s2_q != rxreq_s3_q);
            if (rxreq_s2_q != rxreq_s3_q)
            begin
                rx_word      <= rx_word_l_q;
                rx_ack_tgl_q <= ~rx_ack_tgl_q;
            end
        end
    end

    // Link domain synchronisers; reset also arrives from the core clock
    always_ff @(posedge link_clock)
    begin
        lrst_s1_q  <= reset;
        lrst       <= lrst_s1_q;
        en_s1_q    <= slave_mode_q;
        en_s2_q    <= en_s1_q;
        nat_s1_q   <= native_flow_enable;
        nat_s2_q   <= nat_s1_q;
        lines_s1_q <= '{clk: port_bit_clock_in,
                        dat: port_serial_data_in};
        lines_s2_q <= lines_s1_q;
        lines_p_q  <= lines_s2_q;
        txreq_s1_q <= tx_req_tgl_q;
        txreq_s2_q <= txreq_s1_q;
        txreq_s3_q <= txreq_s2_q;
        rxack_s1_q <= rx_ack_tgl_q;
        rxack_s2_q <= rxack_s1_q;
        rxack_s3_q <= rxack_s2_q;
    end

    // Edge and condition decode on synchronised lines only
    always_comb
    begin
        scl_rise = lines_s2_q.clk & ~lines_p_q.clk;
        scl_fall = ~lines_s2_q.clk & lines_p_q.clk;
        start_w  = lines_s2_q.clk & lines_p_q.clk
                 & lines_p_q.dat & ~lines_s2_q.dat;
        stop_w   = lines_s2_q.clk & lines_p_q.clk
                 & ~lines_p_q.dat & lines_s2_q.dat;
        tx_new      = txreq_s2_q != txreq_s3_q;
        rx_ack_seen = rxack_s2_q != rxack_s3_q;
        addr_hit    = (sh_q == hcp_pkg::ADDR_WRITE)
                    | (sh_q == hcp_pkg::ADDR_READ);
        // Word goes out most significant byte first
        tx_byte = tx_word_l_q[8*(WORD_BYTES-1-int'(rd_idx_q)) +: 8];
    end

    // Bus occupancy; repeated start simply keeps it set
    always_ff @(posedge link_clock)
    begin
        if (lrst || stop_w)
            bus_busy_q <= 1'b0;
        else if (start_w)
            bus_busy_q <= 1'b1;
    end

    // Transfer sequencer with receive word and send word slots
    always_ff @(posedge link_clock)
    begin
        if (lrst)
        begin
            state_q      <= hcp_pkg::HCP_IDLE;
            cnt_q        <= hcp_pkg::BIT_CNT_ZERO;
            sh_q         <= '0;
            tx_sh_q      <= '0;
            rw_q         <= 1'b0;
            mack_q       <= 1'b0;
            full_q       <= 1'b0;
            tx_have_q    <= 1'b0;
            loaded_q     <= 1'b0;
            wr_idx_q     <= '0;
            rd_idx_q     <= '0;
            rx_word_l_q  <= '0;
            tx_word_l_q  <= '0;
            rx_req_tgl_q <= 1'b0;
            tx_ack_tgl_q <= 1'b0;
            port_serial_data_oe <= 1'b0;
        end
        else
        begin
            // Core took the word; full only ever clears after a set
            if (rx_ack_seen)
            begin
                full_q   <= 1'b0;
                wr_idx_q <= '0;
            end
            if (tx_new)
            begin
                tx_have_q   <= 1'b1;
                tx_word_l_q <= tx_hold_q;
                rd_idx_q    <= '0;
            end
            if (!en_s2_q)
            begin
                state_q             <= hcp_pkg::HCP_IDLE;
                port_serial_data_oe <= 1'b0;
            end
            else if (start_w)
            begin
                // Repeated start restarts address phase too
                state_q             <= hcp_pkg::HCP_ADDR;
                cnt_q               <= hcp_pkg::BIT_CNT_ZERO;
                port_serial_data_oe <= 1'b0;
            end
            else if (stop_w)
            begin
                state_q             <= hcp_pkg::HCP_IDLE;
                port_serial_data_oe <= 1'b0;
            end
            else
            begin
                unique case (state_q)
                    hcp_pkg::HCP_IDLE:
                    begin
                        port_serial_data_oe <= 1'b0;
                    end
                    hcp_pkg::HCP_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            // Address and direction, MSB first
                            sh_q  <= {sh_q[6:0], lines_s2_q.dat};
                            cnt_q <= cnt_q + 4'h1;
                        end
                        else if (scl_fall &&
                                 cnt_q == hcp_pkg::BIT_CNT_DONE)
                        begin
                            // Ack drives low only on a matching address
                            state_q <= addr_hit ? hcp_pkg::HCP_ACK
                                                : hcp_pkg::HCP_IDLE;
                            port_serial_data_oe <= addr_hit;
                            rw_q    <= sh_q[0];
                        end
                    end
                    hcp_pkg::HCP_WRITE:
                    begin
                        if (scl_rise)
                        begin
                            sh_q  <= {sh_q[6:0], lines_s2_q.dat};
                            cnt_q <= cnt_q + 4'h1;
                        end
                        else if (scl_fall &&
                                 cnt_q == hcp_pkg::BIT_CNT_DONE)
                        begin
                            state_q <= hcp_pkg::HCP_ACK;
                            // A byte landing on a full buffer is lost
                            port_serial_data_oe <= ~full_q;
                            if (!full_q)
                            begin
                                rx_word_l_q[8*(WORD_BYTES-1-int'(wr_idx_q))
                                            +: 8] <= sh_q;
                                wr_idx_q <= wr_idx_q + IW'(1);
                                if (wr_idx_q == LAST_IDX)
                                begin
                                    full_q       <= 1'b1;
                                    rx_req_tgl_q <= ~rx_req_tgl_q;
                                end
                            end
                        end
                    end
                    hcp_pkg::HCP_ACK:
                    begin
                        if (scl_fall)
                        begin
                            port_serial_data_oe <= 1'b0;
                            cnt_q    <= hcp_pkg::BIT_CNT_ZERO;
                            loaded_q <= 1'b0;
                            state_q  <= rw_q ? hcp_pkg::HCP_READ
                                             : hcp_pkg::HCP_WRITE;
                        end
                    end
                    hcp_pkg::HCP_READ:
                    begin
                        if (scl_rise)
                            cnt_q <= cnt_q + 4'h1;
                        else if (scl_fall)
                        begin
                            if (cnt_q == hcp_pkg::BIT_CNT_DONE)
                            begin
                                port_serial_data_oe <= 1'b0;
                                state_q <= hcp_pkg::HCP_RACK;
                                if (loaded_q && rd_idx_q == LAST_IDX)
                                begin
                                    tx_have_q    <= 1'b0;
                                    tx_ack_tgl_q <= ~tx_ack_tgl_q;
                                    rd_idx_q     <= '0;
                                end
                                else if (loaded_q)
                                    rd_idx_q <= rd_idx_q + IW'(1);
                            end
                            else if (loaded_q)
                            begin
                                // Next bit changes only while clock is low
                                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                                port_serial_data_oe <= ~tx_sh_q[6];
                            end
                        end
                        else if (cnt_q == hcp_pkg::BIT_CNT_ZERO &&
                                 !loaded_q && tx_have_q)
                        begin
                            tx_sh_q  <= tx_byte;
                            loaded_q <= 1'b1;
                            port_serial_data_oe <= ~tx_byte[7];
                        end
                    end
                    hcp_pkg::HCP_RACK:
                    begin
                        // Master ack means another byte, nack ends it
                        if (scl_rise)
                            mack_q <= ~lines_s2_q.dat;
                        else if (scl_fall)
                        begin
                            cnt_q    <= hcp_pkg::BIT_CNT_ZERO;
                            loaded_q <= 1'b0;
                            state_q  <= mack_q ? hcp_pkg::HCP_READ
                                               : hcp_pkg::HCP_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Open-drain pins only ever pull low; busy mirrors the full flag
    always_ff @(posedge link_clock)
    begin
        port_serial_data_out <= 1'b0;
        port_bit_clock_out   <= 1'b0;
        if (lrst)
        begin
            input_full_n      <= 1'b1;
            port_bit_clock_oe <= 1'b0;
        end
        else
        begin
            input_full_n <= ~full_q;
            // Clock only held low; a read stalls only with no word on hand,
            // and lets go one cycle after loading so data leads the clock
            port_bit_clock_oe <= nat_s2_q & en_s2_q
                & (cnt_q == hcp_pkg::BIT_CNT_ZERO)
                & (((state_q == hcp_pkg::HCP_WRITE) & full_q)
                 | ((state_q == hcp_pkg::HCP_READ) & ~loaded_q
                    & (~tx_have_q | port_bit_clock_oe)));
        end
    end

    // Checks on the link side
    property p_busy_full;
        @(posedge link_clock) disable iff (lrst)
        full_q |=> !input_full_n;
    endproperty
    a_busy_full: assert property (p_busy_full)
        else $error("busy line not low while buffer full");

    property p_addr_ack;
        @(posedge link_clock) disable iff (lrst)
        (en_s2_q && !start_w && !stop_w && state_q == hcp_pkg::HCP_ADDR
         && scl_fall && cnt_q == hcp_pkg::BIT_CNT_DONE && addr_hit)
        |=> port_serial_data_oe && state_q == hcp_pkg::HCP_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("matching address not acknowledged");

    property p_addr_nack;
        @(posedge link_clock) disable iff (lrst)
        (state_q == hcp_pkg::HCP_ADDR && scl_fall && !addr_hit
         && cnt_q == hcp_pkg::BIT_CNT_DONE)
        |=> !port_serial_data_oe [*2];
    endproperty
    a_addr_nack: assert property (p_addr_nack)
        else $error("foreign address acknowledged");

    property p_drop_full;
        @(posedge link_clock) disable iff (lrst)
        (state_q == hcp_pkg::HCP_WRITE && scl_fall && full_q && en_s2_q
         && cnt_q == hcp_pkg::BIT_CNT_DONE && !start_w && !stop_w)
        |=> !port_serial_data_oe && $stable(rx_word_l_q);
    endproperty
    a_drop_full: assert property (p_drop_full)
        else $error("byte accepted while buffer full");

    property p_release;
        @(posedge link_clock) disable iff (lrst)
        (state_q == hcp_pkg::HCP_ACK && scl_fall) |=> !port_serial_data_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("data line held after acknowledge");

    property p_start;
        @(posedge link_clock) disable iff (lrst)
        (start_w && en_s2_q) |=> state_q == hcp_pkg::HCP_ADDR
            && cnt_q == hcp_pkg::BIT_CNT_ZERO && bus_busy_q;
    endproperty
    a_start: assert property (p_start)
        else $error("start not decoded");

    property p_stop;
        @(posedge link_clock) disable iff (lrst)
        stop_w |=> state_q == hcp_pkg::HCP_IDLE && !bus_busy_q;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop not decoded");

    property p_stable_high;
        @(posedge link_clock) disable iff (lrst)
        (lines_s2_q.clk && lines_p_q.clk && !start_w && !stop_w)
        |=> $stable(port_serial_data_oe);
    endproperty
    a_stable_high: assert property (p_stable_high)
        else $error("data changed while clock high");

    property p_stretch;
        @(posedge link_clock) disable iff (lrst)
        port_bit_clock_oe |-> $past(nat_s2_q) && !port_bit_clock_out;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("clock held without native flow mode");

    // Checks on the core side
    property p_request;
        @(posedge clock) disable iff (reset)
        (tx_valid && tx_ready) |=> ##1 !data_ready_request_n [*2];
    endproperty
    a_request: assert property (p_request)
        else $error("request line not low with word waiting");

    property p_boot;
        @(posedge clock)
        (reset_d1_q && !reset) |=> boot_mode == $past(bsel_s2_q);
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot pins not captured at release");

    c_word_in: cover property (@(posedge clock) rx_valid);
    c_word_out: cover property (@(posedge clock)
        tx_busy_q && txack_s2_q != txack_s3_q);
    c_stretch: cover property (@(posedge link_clock) port_bit_clock_oe);
    c_nack: cover property (@(posedge link_clock)
        state_q == hcp_pkg::HCP_ADDR && scl_fall && !addr_hit
        && cnt_q == hcp_pkg::BIT_CNT_DONE);

endmodule : hcp_control_port

`default_nettype wire

// ===== rtl/hcp_pkg.sv
// Shared constants and types for the host control port
package hcp_pkg;

    // Bus addresses answered by the port
    localparam logic [7:0] ADDR_WRITE = 8'h80;
    localparam logic [7:0] ADDR_READ  = 8'h81;

    // Bit counter value once a whole byte has been clocked
    localparam logic [3:0] BIT_CNT_DONE = 4'h8;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;

    // Reset values
    localparam logic [4:0] BOOT_SEL_RESET = 5'h00;

    // Sampled bus lines travel together
    typedef struct packed {
        logic clk;
        logic dat;
    } hcp_lines_t;

    // Idle bus, both lines pulled high
    localparam hcp_lines_t LINES_IDLE = '{clk: 1'b1, dat: 1'b1};

    // Link-side transfer phases
    typedef enum logic [2:0] {
        HCP_IDLE,
        HCP_ADDR,
        HCP_ACK,
        HCP_WRITE,
        HCP_READ,
        HCP_RACK
    } hcp_state_t;

endpackage : hcp_pkg

// ===== sim/hcp_host_model.sv
// Bus master model for the two-wire control port
`timescale 1ns/1ps
`default_nettype none

module hcp_host_model (
    output var  logic scl_oe,
    output var  logic sda_oe,
    input  wire logic scl,
    input  wire logic sda
);
    localparam int HALF = 200;
    // Clock waits that ran out of patience
    int stalls = 0;

    // Both lines released at time zero, pull-ups give idle high
    initial
    begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    // Data falls while the clock is high
    task automatic start();
        sda_oe = 1'b1;
        #HALF scl_oe = 1'b1;
        #HALF;
    endtask : start

    // Data rises while the clock is high
    task automatic stop();
        sda_oe = 1'b1;
        #HALF scl_oe = 1'b0;
        #HALF sda_oe = 1'b0;
        #HALF;
    endtask : stop

    // Nine clocks, first bit first; a 1 leaves the line to the slave
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        int n;
        for (int i = 8; i >= 0; i--)
        begin
            sda_oe = ~tx[i];
            #HALF scl_oe = 1'b0;
            n = 0;
            // Slave may hold the clock low; bounded so a hang ends
            while (scl !== 1'b1 && n < 5000)
            begin
                #10 n++;
            end
            if (n >= 5000)
                stalls++;
            #HALF rx[i] = sda;
            scl_oe = 1'b1;
        end
    endtask : xfer
endmodule : hcp_host_model
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the host control port
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        clock = 1'b0;
    logic        link_clock = 1'b0;
    logic        reset = 1'b1;
    logic [31:0] tx_word = 32'h0;
    logic        tx_valid = 1'b0;
    logic        scl_oe, sda_oe, pscl_oe, psda_oe, drr_n, full_n, rx_valid;
    logic        tx_ready, full_seen = 1'b0;
    logic [4:0]  boot_mode, boot_pins = 5'h01;
    logic        native = 1'b1;
    logic [31:0] rx_word, rx_seen;
    int          errors = 0, comparisons = 0, rx_count = 0, stretch_cnt = 0;
    // Open-drain wires: low when anyone pulls
    wire logic   scl = ~(scl_oe | pscl_oe);
    wire logic   sda = ~(sda_oe | psda_oe);

    always #5 clock = ~clock;
    always #6 link_clock = ~link_clock;

    hcp_control_port hcp_control_port_inst (.clock(clock), .reset(reset),
        .link_clock(link_clock), .boot_select_pins(boot_pins),
        .native_flow_enable(native), .port_bit_clock_in(scl),
        .port_bit_clock_out(), .port_bit_clock_oe(pscl_oe),
        .port_serial_data_in(sda), .port_serial_data_out(),
        .port_serial_data_oe(psda_oe), .data_ready_request_n(drr_n),
        .input_full_n(full_n), .boot_mode(boot_mode), .rx_word(rx_word),
        .rx_valid(rx_valid), .tx_word(tx_word), .tx_valid(tx_valid),
        .tx_ready(tx_ready));
    hcp_host_model host_inst (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl),
        .sda(sda));

    // Catch the one-cycle word pulse and any busy period
    always @(posedge clock)
    begin
        if (rx_valid === 1'b1)
        begin
            rx_seen <= rx_word;
            rx_count <= rx_count + 1;
        end
        if (full_n === 1'b0)
            full_seen <= 1'b1;
        if (pscl_oe === 1'b1)
            stretch_cnt <= stretch_cnt + 1;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic write_word(input logic [31:0] w);
        logic [8:0] r;
        int n;
        host_inst.start();
        host_inst.xfer({hcp_pkg::ADDR_WRITE, 1'b1}, r);
        check("wr addr ack", {31'h0, r[0]}, 32'h0);
        for (int b = 3; b >= 0; b--)
        begin
            n = 0;
            while (full_n === 1'b0 && n < 500)
            begin
                #10 n++;
            end
            if (n >= 500)
                errors++;
            host_inst.xfer({w[8*b+:8], 1'b1}, r);
            check("wr data ack", {31'h0, r[0]}, 32'h0);
        end
        #300 check("sda free", {31'h0, sda}, 32'h1);
        host_inst.stop();
        n = 0;
        while (rx_count == 0 && n < 200)
        begin
            @(posedge clock);
            n++;
        end
        check("rx word", rx_seen, w);
        check("full seen", {31'h0, full_seen}, 32'h1);
        repeat (40) @(posedge clock);
        check("full_n", {31'h0, full_n}, 32'h1);
    endtask : write_word

    // Foreign address gets no acknowledge
    task automatic bad_address();
        logic [8:0] r;
        host_inst.start();
        host_inst.xfer({8'h42, 1'b1}, r);
        check("nack", {31'h0, r[0]}, 32'h1);
        host_inst.stop();
    endtask : bad_address

    // Core offers a word; the request line must fall
    task automatic give_word(input logic [31:0] w);
        check("tx_ready", {31'h0, tx_ready}, 32'h1);
        @(posedge clock);
        #1 tx_word = w;
        tx_valid = 1'b1;
        @(posedge clock);
        #1 tx_valid = 1'b0;
        repeat (4) @(posedge clock);
        check("drr_n low", {31'h0, drr_n}, 32'h0);
    endtask : give_word

    // Late word arrives mid-read, so the port must stall the clock
    task automatic read_word(input logic [31:0] w, input logic late);
        logic [8:0] r;
        int s0;
        s0 = stretch_cnt;
        if (!late)
            give_word(w);
        host_inst.start();
        host_inst.xfer({hcp_pkg::ADDR_READ, 1'b1}, r);
        check("rd addr ack", {31'h0, r[0]}, 32'h0);
        for (int b = 3; b >= 0; b--)
        begin
            if (late && b == 3)
                fork
                    host_inst.xfer({8'hFF, 1'b0}, r);
                    begin
                        repeat (60) @(posedge clock);
                        give_word(w);
                    end
                join
            else
                host_inst.xfer({8'hFF, b == 0}, r);
            check("rd byte", {24'h0, r[8:1]}, {24'h0, w[8*b+:8]});
        end
        host_inst.stop();
        repeat (20) @(posedge clock);
        check("drr_n high", {31'h0, drr_n}, 32'h1);
        check("stretch", {31'h0, stretch_cnt != s0}, {31'h0, late});
    endtask : read_word

    // No word and no native flow: bits read high, clock never held
    task automatic empty_read();
        logic [8:0] r;
        int s0;
        @(posedge clock);
        #1 native = 1'b0;
        repeat (10) @(posedge clock);
        s0 = stretch_cnt;
        host_inst.start();
        host_inst.xfer({hcp_pkg::ADDR_READ, 1'b1}, r);
        host_inst.xfer({8'hFF, 1'b1}, r);
        check("empty byte", {24'h0, r[8:1]}, 32'hFF);
        check("no stretch", stretch_cnt - s0, 32'h0);
        host_inst.stop();
        @(posedge clock);
        #1 native = 1'b1;
    endtask : empty_read

    // Second reset with a non-slave strap: port stays silent
    task automatic other_boot();
        logic [8:0] r;
        @(posedge clock);
        #1 reset = 1'b1;
        boot_pins = 5'h02;
        repeat (6) @(posedge clock);
        #1 reset = 1'b0;
        repeat (20) @(posedge clock);
        check("boot_mode 2", {27'h0, boot_mode}, 32'h2);
        host_inst.start();
        host_inst.xfer({hcp_pkg::ADDR_WRITE, 1'b1}, r);
        check("off nack", {31'h0, r[0]}, 32'h1);
        host_inst.stop();
    endtask : other_boot

    initial
    begin
        repeat (6) @(posedge clock);
        #1 reset = 1'b0;
        repeat (20) @(posedge clock);
        check("boot_mode", {27'h0, boot_mode}, 32'h1);
        write_word(32'hA55A_0F81);
        bad_address();
        read_word(32'h81C3_7E01, 1'b0);
        read_word(32'h3C96_E718, 1'b1);
        empty_read();
        other_boot();
        check("host stalls", host_inst.stalls, 32'h0);
        report_and_stop();
    end

    // Hang guard
    initial
    begin
        #900000 errors++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
